// ==== tb_tocm_output_compare.sv ====
// Self-checking bench for the channel 1/2 output-compare block.
`default_nettype none

module tb_tocm_output_compare;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
    logic [3:0] sel = 4'h0;
    logic [15:0] cnt = 16'h0;
    logic down = 1'b0, upd = 1'b0, etr = 1'b0, ti1 = 1'b0, ti2 = 1'b0;
    logic trig = 1'b0, com = 1'b0, commutation_preload_control = 1'b0, itsrc = 1'b0, itsel = 1'b0;
    logic [1:0] lock = 2'h0, opol = 2'h0, cpol = 2'h0, oen = 2'h0, cen = 2'h0;
    logic [1:0] ref_o, main_o, comp_o, cap_o;
    logic comb_o;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    // Channel 2 parked in force-high so both reference bits are always checked
    localparam logic [31:0] CH2_HI = 32'h0000_5000;

    tocm_output_compare i_tocm_output_compare (.CLOCK(clock), .SRST(srst), .ADR_I(adr), .DAT_I(wdat),
        .DAT_O(rdat), .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .COUNTER_VALUE(cnt),
        .COUNT_DOWN(down), .UPDATE_EVENT(upd), .TRIGGER_INPUT(trig), .COMMUTATION_EVENT(com),
        .FILTERED_EXTERNAL_TRIGGER(etr), .LOCK_LEVEL(lock), .COMMUTATION_PRELOAD_CONTROL(commutation_preload_control),
        .OUTPUT_POLARITY(opol), .COMPLEMENT_POLARITY(cpol), .OUTPUT_ENABLE(oen), .COMPLEMENT_ENABLE(cen),
        .TIMER_INPUT_1(ti1), .TIMER_INPUT_2(ti2), .INTERNAL_TRIGGER_SOURCE(itsrc),
        .INTERNAL_TRIGGER_SELECTED(itsel), .REFERENCE(ref_o), .CH1_COMBINED_REFERENCE(comb_o),
        .MAIN_OUTPUT(main_o), .COMPLEMENT_OUTPUT(comp_o), .CAPTURE_INPUT(cap_o));

    // 25 MHz kernel clock
    initial begin
        forever #20 clock = ~clock;
    end

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("Counts: %0d checks, %0d mismatches", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        if (n >= 16) begin
            miscompares++;
            $display("MISMATCH bus ack expected 1 seen %b", ack);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk("read data", exp, q);
    endtask : rd

    function automatic logic [31:0] ctl(input logic [3:0] m, input logic clr, input logic pre);
        ctl = CH2_HI;
        ctl[16] = m[3];
        ctl[6:4] = m[2:0];
        ctl[7] = clr;
        ctl[3] = pre;
    endfunction : ctl

    task automatic wr1(input logic [3:0] m, input logic clr, input logic pre);
        wb(1'b1, tocm_pkg::CTRL_OFS, ctl(m, clr, pre));
    endtask : wr1

    task automatic drive_cnt(input logic [15:0] v, input logic dn);
        @(posedge clock);
        cnt <= v;
        down <= dn;
    endtask : drive_cnt

    // Mode copy plus registered output land within four edges
    task automatic see(input string what, input logic [1:0] exp);
        repeat (4) @(posedge clock);
        chk(what, {30'h0, exp}, {30'h0, ref_o});
    endtask : see

    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        rd(tocm_pkg::CTRL_OFS, 32'h0);
        rd(tocm_pkg::CMP1_OFS, 32'h0);
        rd(8'h40, 32'h0);
        see("reset reference", 2'b00);
        $display("TEST reset finished");
        // Forced levels and polarity paths
        @(posedge clock);
        oen <= 2'h3;
        cen <= 2'h3;
        opol <= 2'h1;
        wr1(4'h5, 1'b0, 1'b0);
        wb(1'b1, tocm_pkg::CTRL_OFS, ctl(4'h5, 1'b0, 1'b0) & 32'hffff_0fff | 32'h0000_4000);
        rd(tocm_pkg::CTRL_OFS, 32'h0000_4050);
        see("force levels", 2'b01);
        chk("main output", 32'h0, {30'h0, main_o});
        chk("complement output", 32'h2, {30'h0, comp_o});
        wr1(4'h4, 1'b0, 1'b0);
        see("force low ch1", 2'b10);
        $display("TEST forced finished");
        // Match modes, compare written with preload off acts at once
        wb(1'b1, tocm_pkg::CMP1_OFS, 32'h5);
        drive_cnt(16'h3, 1'b0);
        wr1(4'h1, 1'b0, 1'b0);
        see("set before match", 2'b10);
        drive_cnt(16'h5, 1'b0);
        see("set on match", 2'b11);
        wr1(4'h2, 1'b0, 1'b0);
        see("clear on match", 2'b10);
        drive_cnt(16'h6, 1'b0);
        wr1(4'h3, 1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            drive_cnt(16'h5, 1'b0);
            drive_cnt(16'h6, 1'b0);
            see("toggle", k == 0 ? 2'b11 : 2'b10);
        end
        wr1(4'h0, 1'b0, 1'b0);
        drive_cnt(16'h3, 1'b0);
        see("frozen", 2'b10);
        $display("TEST match finished");
        // Pulse-width modes 1/2, both directions, either side of compare 5
        for (int i = 0; i < 8; i++) begin
            wr1(4'h0, 1'b0, 1'b0);
            drive_cnt(i[0] ? 16'h7 : 16'h3, i[1]);
            wr1(i[2] ? 4'h7 : 4'h6, 1'b0, 1'b1);
            see("pulse width", {1'b1, i[0] ^ ~i[2]});
        end
        $display("TEST pulse width finished");
        // Clear input only matters with clear-enable set
        drive_cnt(16'h3, 1'b0);
        wr1(4'h5, 1'b1, 1'b0);
        @(posedge clock);
        etr <= 1'b1;
        see("clear enabled", 2'b10);
        wr1(4'h5, 1'b0, 1'b0);
        see("clear ignored", 2'b11);
        @(posedge clock);
        etr <= 1'b0;
        lock <= tocm_pkg::LOCK_LEVEL3;
        wr1(4'h4, 1'b0, 1'b1);
        rd(tocm_pkg::CTRL_OFS, ctl(4'h5, 1'b0, 1'b0));
        see("locked mode", 2'b11);
        @(posedge clock);
        lock <= 2'h0;
        $display("TEST clear and lock finished");
        // Direction guard and capture routing
        @(posedge clock);
        oen <= 2'h2;
        cen <= 2'h0;
        wb(1'b1, tocm_pkg::CTRL_OFS, 32'h0000_5100);
        rd(tocm_pkg::CTRL_OFS, 32'h0000_5000);
        @(posedge clock);
        oen <= 2'h0;
        ti2 <= 1'b1;
        wb(1'b1, tocm_pkg::CTRL_OFS, 32'h0000_5100);
        repeat (4) @(posedge clock);
        chk("capture ch2 same", 32'h2, {30'h0, cap_o});
        wb(1'b1, tocm_pkg::CTRL_OFS, 32'h0000_5201);
        @(posedge clock);
        ti1 <= 1'b1;
        repeat (4) @(posedge clock);
        chk("capture cross", 32'h3, {30'h0, cap_o});
        wb(1'b1, tocm_pkg::CTRL_OFS, CH2_HI);
        $display("TEST direction finished");
        // Preloaded compare waits for the update event
        drive_cnt(16'h9, 1'b0);
        wr1(4'h4, 1'b0, 1'b0);
        wr1(4'h1, 1'b0, 1'b1);
        wb(1'b1, tocm_pkg::CMP1_OFS, 32'h9);
        see("shadow only", 2'b10);
        rd(tocm_pkg::CMP1_OFS, 32'h9);
        @(posedge clock);
        upd <= 1'b1;
        @(posedge clock);
        upd <= 1'b0;
        see("after update", 2'b11);
        wr1(4'h4, 1'b0, 1'b0);
        wr1(4'h8, 1'b0, 1'b0);
        see("one pulse idle", 2'b11);
        wr1(4'h9, 1'b0, 1'b0);
        see("one pulse two idle", 2'b10);
        $display("TEST preload finished");
        // Combined outputs; ch2 stays high so OR, AND and ch2 pick differ
        wr1(4'h0, 1'b0, 1'b0);
        drive_cnt(16'hb, 1'b0);
        wr1(4'hc, 1'b0, 1'b1);
        see("combined or ref", 2'b10);
        chk("combined or", 32'h1, {31'h0, comb_o});
        wr1(4'h0, 1'b0, 1'b0);
        drive_cnt(16'h3, 1'b0);
        wr1(4'hd, 1'b0, 1'b1);
        see("combined and ref", 2'b10);
        chk("combined and", 32'h0, {31'h0, comb_o});
        wr1(4'h0, 1'b0, 1'b0);
        drive_cnt(16'hb, 1'b1);
        wr1(4'he, 1'b0, 1'b1);
        see("asymmetric ref", 2'b10);
        chk("asymmetric", 32'h1, {31'h0, comb_o});
        // One-pulse: trigger arms, update returns to idle
        drive_cnt(16'hb, 1'b0);
        wr1(4'h8, 1'b0, 1'b0);
        see("one pulse before trigger", 2'b11);
        @(posedge clock);
        trig <= 1'b1;
        @(posedge clock);
        trig <= 1'b0;
        see("one pulse armed", 2'b10);
        @(posedge clock);
        upd <= 1'b1;
        @(posedge clock);
        upd <= 1'b0;
        see("one pulse after update", 2'b11);
        // Fast enable: trigger forces the match level
        wr1(4'h0, 1'b0, 1'b0);
        drive_cnt(16'h3, 1'b0);
        wb(1'b1, tocm_pkg::CTRL_OFS, ctl(4'h6, 1'b0, 1'b1) | 32'h0000_0004);
        see("fast before trigger", 2'b11);
        @(posedge clock);
        trig <= 1'b1;
        @(posedge clock);
        trig <= 1'b0;
        see("fast trigger", 2'b10);
        // Commutation preload holds the new mode until the event
        @(posedge clock);
        commutation_preload_control <= 1'b1;
        wr1(4'h5, 1'b0, 1'b0);
        see("mode held", 2'b10);
        @(posedge clock);
        com <= 1'b1;
        @(posedge clock);
        com <= 1'b0;
        commutation_preload_control <= 1'b0;
        see("mode on commutation", 2'b11);
        // Internal trigger routing and ch1 crossed input
        @(posedge clock);
        ti2 <= 1'b0;
        itsrc <= 1'b1;
        itsel <= 1'b1;
        wb(1'b1, tocm_pkg::CTRL_OFS, 32'h0000_5302);
        repeat (4) @(posedge clock);
        chk("capture internal", 32'h2, {30'h0, cap_o});
        $display("TEST combined and trigger finished");
        wrap_up();
    end
endmodule : tb_tocm_output_compare

`default_nettype wire

// ==== tocm_output_compare.sv ====
// Output-compare reference generation for timer channels 1 and 2 with a Wishbone register slave.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`default_nettype none

module tocm_output_compare (
    input wire logic CLOCK, // Timer kernel clock
    input wire logic SRST, // Synchronous reset, active high
    input wire logic [7:0] ADR_I, // Wishbone byte address
    input wire logic [31:0] DAT_I, // Wishbone write data
    output logic [31:0] DAT_O, // Wishbone read data
    input wire logic WE_I, // Wishbone write enable
    input wire logic [3:0] SEL_I, // Wishbone byte selects
    input wire logic CYC_I, // Wishbone cycle
    input wire logic STB_I, // Wishbone strobe
    output logic ACK_O, // Wishbone acknowledge
    input wire logic [15:0] COUNTER_VALUE, // Timer counter
    input wire logic COUNT_DOWN, // Counter direction, high when counting down
    input wire logic UPDATE_EVENT, // Update event pulse
    input wire logic TRIGGER_INPUT, // Trigger event pulse
    input wire logic COMMUTATION_EVENT, // Commutation event pulse
    input wire logic FILTERED_EXTERNAL_TRIGGER, // Reference clear level
    input wire logic [1:0] LOCK_LEVEL, // Lock level
    input wire logic COMMUTATION_PRELOAD_CONTROL, // Mode loads only on commutation
    input wire logic [1:0] OUTPUT_POLARITY, // Main output polarity per channel
    input wire logic [1:0] COMPLEMENT_POLARITY, // Complement polarity per channel
    input wire logic [1:0] OUTPUT_ENABLE, // Main output enable per channel
    input wire logic [1:0] COMPLEMENT_ENABLE, // Complement enable per channel
    input wire logic TIMER_INPUT_1, // Timer input 1
    input wire logic TIMER_INPUT_2, // Timer input 2
    input wire logic INTERNAL_TRIGGER_SOURCE, // Internal trigger source
    input wire logic INTERNAL_TRIGGER_SELECTED, // Internal trigger picked as trigger
    output logic [1:0] REFERENCE, // Channel references, active high
    output logic CH1_COMBINED_REFERENCE, // Channel 1 combined reference
    output logic [1:0] MAIN_OUTPUT, // Main output levels
    output logic [1:0] COMPLEMENT_OUTPUT, // Complement output levels
    output logic [1:0] CAPTURE_INPUT // Routed capture inputs
);

    tocm_pkg::tocm_state_s state_r;
    tocm_pkg::tocm_state_s state_nxt;

    // Pulse-width mode 1 level; mode 2 is its inverse
    function automatic logic pwm1_level(input logic down, input logic [15:0] cnt, input logic [15:0] cmp);
        logic lvl;
        lvl = down ? (cnt <= cmp) : (cnt < cmp);
        return lvl;
    endfunction : pwm1_level

    // Control word as software reads it back
    function automatic logic [31:0] ctrl_word(input tocm_pkg::tocm_state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < 2; i++) begin
            w[tocm_pkg::DIR_POS + tocm_pkg::CH_STRIDE * i +: 2] = s.dir[i];
            w[tocm_pkg::FAST_POS + tocm_pkg::CH_STRIDE * i] = s.fast_en[i];
            w[tocm_pkg::PRE_POS + tocm_pkg::CH_STRIDE * i] = s.pre_en[i];
            w[tocm_pkg::MODE_LO_POS + tocm_pkg::CH_STRIDE * i +: 3] = s.mode_pre[i][2:0];
            w[tocm_pkg::CLR_POS + tocm_pkg::CH_STRIDE * i] = s.clr_en[i];
            w[tocm_pkg::MODE_HI_POS + tocm_pkg::CH_STRIDE * i] = s.mode_pre[i][3];
        end
        return w;
    endfunction : ctrl_word

    // Next state of the whole block
    always_comb begin
        logic [31:0] bmask;
        logic [31:0] w;
        logic [31:0] rd;
        logic [15:0] cmp_new;
        logic [3:0] m;
        logic wr;
        logic locked;
        logic lvl;
        logic ref_v;
        logic match;
        logic is_pwm;
        bmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
        w = 32'h0000_0000;
        rd = tocm_pkg::RDATA_UNMAPPED;
        cmp_new = 16'h0000;
        m = 4'h0;
        wr = 1'b0;
        locked = 1'b0;
        lvl = 1'b0;
        ref_v = 1'b0;
        match = 1'b0;
        is_pwm = 1'b0;
        state_nxt = state_r;

        // Single-cycle slave: ack one cycle after the request, dropped the next
        state_nxt.ack = CYC_I && STB_I && !state_r.ack;
        wr = state_nxt.ack && WE_I;
        unique case (ADR_I)
            tocm_pkg::CTRL_OFS: rd = ctrl_word(state_r);
            tocm_pkg::CMP1_OFS: rd = {16'h0000, state_r.cmp_shadow[0]};
            tocm_pkg::CMP2_OFS: rd = {16'h0000, state_r.cmp_shadow[1]};
            tocm_pkg::STAT_OFS: begin
                rd[tocm_pkg::ST_REF_POS +: 2] = state_r.ref_q;
                rd[tocm_pkg::ST_COMB_POS] = state_r.comb;
                rd[tocm_pkg::ST_ARMED_POS +: 2] = state_r.armed;
                rd[tocm_pkg::ST_MODE_POS +: 8] = state_r.mode_act;
            end
            default: rd = tocm_pkg::RDATA_UNMAPPED;
        endcase
        state_nxt.rdata = (state_nxt.ack && !WE_I) ? rd : 32'h0000_0000;

        // Control register write, byte lanes merged onto the current contents
        if (wr && ADR_I == tocm_pkg::CTRL_OFS) begin
            w = (ctrl_word(state_r) & ~bmask) | (DAT_I & bmask);
            for (int i = 0; i < 2; i++) begin
                locked = (LOCK_LEVEL == tocm_pkg::LOCK_LEVEL3) && (state_r.dir[i] == tocm_pkg::DIR_OUT);
                if (!locked) begin
                    state_nxt.mode_pre[i] = {w[tocm_pkg::MODE_HI_POS + tocm_pkg::CH_STRIDE * i],
                        w[tocm_pkg::MODE_LO_POS + tocm_pkg::CH_STRIDE * i +: 3]};
                    state_nxt.pre_en[i] = w[tocm_pkg::PRE_POS + tocm_pkg::CH_STRIDE * i];
                end
                state_nxt.clr_en[i] = w[tocm_pkg::CLR_POS + tocm_pkg::CH_STRIDE * i];
                state_nxt.fast_en[i] = w[tocm_pkg::FAST_POS + tocm_pkg::CH_STRIDE * i];
                // Guard reads the live enable inputs, sampled in the cycle of the write
                if (!OUTPUT_ENABLE[i] && !COMPLEMENT_ENABLE[i]) begin
                    state_nxt.dir[i] = w[tocm_pkg::DIR_POS + tocm_pkg::CH_STRIDE * i +: 2];
                end
            end
        end

        for (int i = 0; i < 2; i++) begin
            // Compare value: shadow always written, active copy at once or on update
            if (wr && ADR_I == (i == 0 ? tocm_pkg::CMP1_OFS : tocm_pkg::CMP2_OFS)) begin
                cmp_new = (state_r.cmp_shadow[i] & ~bmask[15:0]) | (DAT_I[15:0] & bmask[15:0]);
                state_nxt.cmp_shadow[i] = cmp_new;
                if (!state_r.pre_en[i]) begin
                    state_nxt.cmp_act[i] = cmp_new;
                end
            end
            if (UPDATE_EVENT && state_r.pre_en[i]) begin
                state_nxt.cmp_act[i] = state_r.cmp_shadow[i];
            end

            // Mode preload: free-running copy, or held for a commutation event
            if (!COMMUTATION_PRELOAD_CONTROL || COMMUTATION_EVENT) begin
                state_nxt.mode_act[i] = state_nxt.mode_pre[i];
            end

            // One-pulse arming; a trigger in the update cycle wins
            if (TRIGGER_INPUT) begin
                state_nxt.armed[i] = 1'b1;
            end else if (UPDATE_EVENT) begin
                state_nxt.armed[i] = 1'b0;
            end

            m = state_r.mode_act[i];
            match = COUNTER_VALUE == state_r.cmp_act[i];
            lvl = pwm1_level(COUNT_DOWN, COUNTER_VALUE, state_r.cmp_act[i]) ^ m[0];
            is_pwm = (m == tocm_pkg::TOCM_PWM1) || (m == tocm_pkg::TOCM_PWM2) || m[3:2] == 2'b11 ||
                ((m == tocm_pkg::TOCM_OPM1 || m == tocm_pkg::TOCM_OPM2) && state_r.armed[i]);
            ref_v = state_r.ref_q[i];

            unique case (tocm_pkg::tocm_mode_e'(m))
                tocm_pkg::TOCM_FROZEN: ref_v = state_r.ref_q[i];
                tocm_pkg::TOCM_SET_MATCH: ref_v = match ? 1'b1 : ref_v;
                tocm_pkg::TOCM_CLR_MATCH: ref_v = match ? 1'b0 : ref_v;
                tocm_pkg::TOCM_TOGGLE: ref_v = match ? !ref_v : ref_v;
                tocm_pkg::TOCM_FORCE_LOW: ref_v = 1'b0;
                tocm_pkg::TOCM_FORCE_HIGH: ref_v = 1'b1;
                tocm_pkg::TOCM_OPM1, tocm_pkg::TOCM_OPM2: begin
                    // Idle level before the trigger depends on mode and direction
                    if (!state_r.armed[i]) begin
                        ref_v = COUNT_DOWN ^ !m[0];
                    end
                end
                default: ref_v = state_r.ref_q[i]; // Reserved codes hold
            endcase

            // Pulse-width level moves only on a compare change, when leaving frozen, in armed one-pulse modes or on a fast-enable trigger
            if (is_pwm) begin
                // One-pulse modes apply the compare level as soon as the trigger arms them
                if (lvl != state_r.lvl_q[i] || state_r.was_frozen[i] || m[3:1] == 3'b100) begin
                    ref_v = lvl;
                end
                if (state_r.fast_en[i] && TRIGGER_INPUT) begin
                    ref_v = pwm1_level(COUNT_DOWN, state_r.cmp_act[i], state_r.cmp_act[i]) ^ m[0];
                end
            end
            state_nxt.lvl_q[i] = lvl;
            state_nxt.was_frozen[i] = m == tocm_pkg::TOCM_FROZEN;

            // An input channel drives no reference
            if (state_r.dir[i] != tocm_pkg::DIR_OUT) begin
                ref_v = 1'b0;
            end
            // Clear level overrides everything; lands one clock later as outputs are registered
            if (state_r.clr_en[i] && FILTERED_EXTERNAL_TRIGGER) begin
                ref_v = 1'b0;
            end
            state_nxt.ref_q[i] = ref_v;

            // Pin levels: reference through polarity, parked low when disabled
            state_nxt.main_out[i] = OUTPUT_ENABLE[i] && (ref_v ^ OUTPUT_POLARITY[i]);
            state_nxt.comp_out[i] = COMPLEMENT_ENABLE[i] && (!ref_v ^ COMPLEMENT_POLARITY[i]);
        end

        // Combined reference of channel 1
        unique case (tocm_pkg::tocm_mode_e'(state_r.mode_act[0]))
            tocm_pkg::TOCM_COMB1: state_nxt.comb = state_nxt.ref_q[0] | state_nxt.ref_q[1];
            tocm_pkg::TOCM_COMB2: state_nxt.comb = state_nxt.ref_q[0] & state_nxt.ref_q[1];
            tocm_pkg::TOCM_ASYM1, tocm_pkg::TOCM_ASYM2: begin
                state_nxt.comb = COUNT_DOWN ? state_nxt.ref_q[1] : state_nxt.ref_q[0];
            end
            default: state_nxt.comb = state_nxt.ref_q[0];
        endcase

        // Capture input routing; internal source only counts when it is the selected trigger
        unique case (state_r.dir[0])
            tocm_pkg::DIR_SAME: state_nxt.cap[0] = TIMER_INPUT_1;
            tocm_pkg::DIR_CROSS: state_nxt.cap[0] = TIMER_INPUT_2;
            tocm_pkg::DIR_TRC: state_nxt.cap[0] = INTERNAL_TRIGGER_SELECTED && INTERNAL_TRIGGER_SOURCE;
            default: state_nxt.cap[0] = 1'b0;
        endcase
        unique case (state_r.dir[1])
            tocm_pkg::DIR_SAME: state_nxt.cap[1] = TIMER_INPUT_2;
            tocm_pkg::DIR_CROSS: state_nxt.cap[1] = TIMER_INPUT_1;
            tocm_pkg::DIR_TRC: state_nxt.cap[1] = INTERNAL_TRIGGER_SELECTED && INTERNAL_TRIGGER_SOURCE;
            default: state_nxt.cap[1] = 1'b0;
        endcase
    end

    // State register
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_r <= tocm_pkg::STATE_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state flops
    assign ACK_O = state_r.ack;
    assign DAT_O = state_r.rdata;
    assign REFERENCE = state_r.ref_q;
    assign CH1_COMBINED_REFERENCE = state_r.comb;
    assign MAIN_OUTPUT = state_r.main_out;
    assign COMPLEMENT_OUTPUT = state_r.comp_out;
    assign CAPTURE_INPUT = state_r.cap;

    // Checks
    logic ch1_free;
    assign ch1_free = (state_r.dir[0] == tocm_pkg::DIR_OUT) && !(state_r.clr_en[0] && FILTERED_EXTERNAL_TRIGGER);

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    sequence s_bus_req;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence s_ctrl_write;
        s_bus_req ##0 (WE_I && ADR_I == tocm_pkg::CTRL_OFS);
    endsequence

    a_bus_ack_pulse: assert property (s_bus_req |=> ACK_O ##1 !ACK_O)
        else $error("ack not a single cycle after request");
    a_lock_blocks_mode: assert property (
        s_ctrl_write ##0 (LOCK_LEVEL == tocm_pkg::LOCK_LEVEL3 && state_r.dir[0] == tocm_pkg::DIR_OUT)
        |=> $stable(state_r.mode_pre[0]) && $stable(state_r.pre_en[0]))
        else $error("locked mode bits changed");
    a_dir_guard: assert property (
        s_ctrl_write ##0 (OUTPUT_ENABLE[0] || COMPLEMENT_ENABLE[0]) |=> $stable(state_r.dir[0]))
        else $error("direction changed while channel enabled");
    a_clear_low: assert property (
        state_r.clr_en[0] && FILTERED_EXTERNAL_TRIGGER |=> !REFERENCE[0])
        else $error("clear input did not drive reference low");
    a_force_high: assert property (
        ch1_free && state_r.mode_act[0] == tocm_pkg::TOCM_FORCE_HIGH |=> REFERENCE[0])
        else $error("forced high not high");
    a_frozen_hold: assert property (
        ch1_free && state_r.mode_act[0] == tocm_pkg::TOCM_FROZEN |=> $stable(REFERENCE[0]))
        else $error("frozen mode moved reference");
    a_toggle_match: assert property (
        ch1_free && state_r.mode_act[0] == tocm_pkg::TOCM_TOGGLE && COUNTER_VALUE == state_r.cmp_act[0]
        |=> REFERENCE[0] != $past(REFERENCE[0]))
        else $error("toggle on match missing");
    a_shadow_load: assert property (
        UPDATE_EVENT && state_r.pre_en[0] |=> state_r.cmp_act[0] == $past(state_r.cmp_shadow[0]))
        else $error("shadow compare not loaded on update");
    a_comb_or: assert property (
        state_r.mode_act[0] == tocm_pkg::TOCM_COMB1 |=> CH1_COMBINED_REFERENCE == (REFERENCE[0] | REFERENCE[1]))
        else $error("combined reference not OR");
    a_com_hold_mode: assert property (
        COMMUTATION_PRELOAD_CONTROL && !COMMUTATION_EVENT |=> $stable(state_r.mode_act[0]))
        else $error("active mode changed without commutation");
    a_comb_and: assert property (
        state_r.mode_act[0] == tocm_pkg::TOCM_COMB2 |=> CH1_COMBINED_REFERENCE == (REFERENCE[0] & REFERENCE[1]))
        else $error("combined reference not AND");
    a_input_ref_low: assert property (
        state_r.dir[0] != tocm_pkg::DIR_OUT |=> !REFERENCE[0])
        else $error("input channel drove reference");
    a_cmp_direct: assert property (
        s_bus_req ##0 (WE_I && ADR_I == tocm_pkg::CMP1_OFS && SEL_I == 4'hf && !state_r.pre_en[0])
        |=> state_r.cmp_act[0] == $past(DAT_I[15:0]))
        else $error("compare write without preload not applied at once");

endmodule : tocm_output_compare

`default_nettype wire

// ==== tocm_pkg.sv ====
// Constants, mode codes and state layout for the channel 1/2 output-compare block.
// Function
// - Four-bit mode field split: top bits at 16 and 24, low bits at 6:4, 14:12.
// - Clear-enable set: high clear input drives reference low; cleared: clear input ignored.
// - Reference is active high; main and complement levels come through separate polarities.
// - Frozen mode 0000 leaves the reference untouched by compare results.
// - Mode 0001 sets reference on match; mode 0010 clears it on match.
// - Mode 0011 toggles the reference on every match.
// - Mode 0100 holds reference low, 0101 holds it high, regardless of counter.
// - Pulse-width mode 1 counting down: low when counter above compare, else high.
// - Pulse-width mode 2 is the inverse of pulse-width mode 1 in both directions.
// - Mode 1000: idle active (up) or inactive (down) until trigger, then PWM 1 until update.
// - Mode 1001: idle inactive (up) or active (down) until trigger, then PWM 2 until update.
// - Mode 1100: reference as PWM 1, combined output is OR of both references.
// - Modes 1110/1111: PWM 1/2; combined output is ch1 reference up, ch2 reference down.
// - Lock level 3 with channel as output blocks writes to mode and preload-enable bits.
// - In PWM modes reference changes only on compare change or leaving frozen mode; code also moves it in armed one-pulse modes and on a fast-enable trigger.
// - Mode field is preloaded; with commutation preload set it loads only on commutation.
// - Preload off: compare writes act at once; on: shadow copied on each update.
// - Fast-enable makes a trigger act as a compare match, only in PWM modes; code also applies it in armed one-pulse modes.
// - Ch1 direction: 00 output, 01 input 1, 10 input 2, 11 internal trigger source.
// - Ch2 direction: 01 routes input 2, 10 routes input 1 to the ch2 capture input.
// - Direction field writable only while both output enables of the channel are clear.
`default_nettype none

package tocm_pkg;

    // Register byte addresses
    localparam logic [7:0] CTRL_OFS = 8'h18;
    localparam logic [7:0] CMP1_OFS = 8'h34;
    localparam logic [7:0] CMP2_OFS = 8'h38;
    localparam logic [7:0] STAT_OFS = 8'h3c;

    // Control field positions for channel 1; channel 2 sits one stride higher
    localparam int CH_STRIDE = 8;
    localparam int DIR_POS = 0;
    localparam int FAST_POS = 2;
    localparam int PRE_POS = 3;
    localparam int MODE_LO_POS = 4;
    localparam int CLR_POS = 7;
    localparam int MODE_HI_POS = 16;

    // Status field positions
    localparam int ST_REF_POS = 0;
    localparam int ST_COMB_POS = 2;
    localparam int ST_ARMED_POS = 3;
    localparam int ST_MODE_POS = 8;

    // Field values
    localparam logic [1:0] DIR_OUT = 2'h0;
    localparam logic [1:0] DIR_SAME = 2'h1;
    localparam logic [1:0] DIR_CROSS = 2'h2;
    localparam logic [1:0] DIR_TRC = 2'h3;
    localparam logic [1:0] LOCK_LEVEL3 = 2'h3;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    typedef enum logic [3:0] {
        TOCM_FROZEN = 4'h0,
        TOCM_SET_MATCH = 4'h1,
        TOCM_CLR_MATCH = 4'h2,
        TOCM_TOGGLE = 4'h3,
        TOCM_FORCE_LOW = 4'h4,
        TOCM_FORCE_HIGH = 4'h5,
        TOCM_PWM1 = 4'h6,
        TOCM_PWM2 = 4'h7,
        TOCM_OPM1 = 4'h8,
        TOCM_OPM2 = 4'h9,
        TOCM_COMB1 = 4'hc,
        TOCM_COMB2 = 4'hd,
        TOCM_ASYM1 = 4'he,
        TOCM_ASYM2 = 4'hf
    } tocm_mode_e;

    // Whole block state, index 0 is channel 1
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [1:0][3:0] mode_pre;
        logic [1:0][3:0] mode_act;
        logic [1:0] clr_en;
        logic [1:0] pre_en;
        logic [1:0] fast_en;
        logic [1:0][1:0] dir;
        logic [1:0][15:0] cmp_shadow;
        logic [1:0][15:0] cmp_act;
        logic [1:0] ref_q;
        logic [1:0] lvl_q;
        logic [1:0] armed;
        logic [1:0] was_frozen;
        logic comb;
        logic [1:0] main_out;
        logic [1:0] comp_out;
        logic [1:0] cap;
    } tocm_state_s;

    localparam tocm_state_s STATE_RESET = '0;

endpackage : tocm_pkg

`default_nettype wire
